// ===== rtl/dcdcm_top.sv
/*
 * Mode control of the cascaded step-up / step-down converter: configuration,
 * chip modes, modulation choice, lag interval, status flags.
 * Assumes all inputs synchronous to core_clk; comparator inputs already
 * filtered; configuration and mode commands arrive as one-cycle strobes.
 */
// Behaviour
// RULE_01: Step-up enable in Normal, four voltage codes
// RULE_02: Step-up on below threshold, off above hysteresis
// RULE_03: Active flag set when step-up switched on
// RULE_04: Voltage change while enabled discarded, error flagged
// RULE_05: Status bits never change mode or configuration
// RULE_06: Normal mode runs step-down in PWM
// RULE_07: Stop entry switches step-down to PFM
// RULE_08: Auto switching beats wake pin selection
// RULE_09: Neither selected keeps PFM throughout Stop
// RULE_10: Overcurrent in Stop: PWM, interrupt, flag
// RULE_11: Controller re-sends Stop to regain PFM
// RULE_12: Auto switching off after reset, software set
// RULE_13: Auto armed after lag; lag on every PWM-PFM
// RULE_14: Lag select: one ms or hundred us
// RULE_15: Wake pin low PFM, high PWM, no lag
// RULE_16: Stop to Normal: PWM, full current allowed
// RULE_17: Running step-up unchanged across Stop to Normal
// RULE_18: Sleep and Fail-Safe switch both converters off
// RULE_19: Wake in Sleep/Fail-Safe goes Restart, Normal
// RULE_20: Restart ramps converters; reset released above threshold
// RULE_21: Voltage codes 00..11 map 6.7/8/10/12 V
// RULE_22: Comparator results arrive synchronised and filtered
`timescale 1ns/100ps
`default_nettype none
`include "dcdcm_consts.svh"
module dcdcm_top
	import dcdcm_pkg::*;
#(
	parameter int LEVELS = 4,
	parameter int FAULT_W = `DCDCM_FAULT_W,
	parameter int LAG_LONG_CYC = `DCDCM_LAG_LONG_CYC,
	parameter int LAG_SHORT_CYC = `DCDCM_LAG_SHORT_CYC,
	parameter int LAG_CNT_W = 17
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cfgWrStb,
	input wire logic cfgStepUpEn,
	input wire logic [1:0] cfgStepUpSel,
	input wire logic cfgAutoSwitch,
	input wire logic cfgWakeSel,
	input wire logic cfgLagSel,
	input wire logic modeCmdStb,
	input wire logic [1:0] modeCmd,
	input wire logic failSafeReq,
	input wire logic wakeEvent,
	input wire logic wake_input_pin,
	input wire logic loadAbovePfmTh,
	input wire logic buckAboveRstTh,
	input wire logic [LEVELS-1:0] railBelowOnTh,
	input wire logic [LEVELS-1:0] railAboveOffTh,
	input wire logic [FAULT_W-1:0] pinFault,
	input wire logic convStatusClr,
	input wire logic wakeStatusClr,
	input wire logic cmdErrorClr,
	output logic [2:0] chipMode,
	output logic buckEnable,
	output logic buckPwm,
	output logic buckFullCurrent,
	output logic stepUpSwitching,
	output logic step_up_enable,
	output logic [1:0] step_up_voltage_select,
	output logic auto_pulse_width_switch,
	output logic wake_pin_modulation_select,
	output logic mode_change_delay_select,
	output logic [`DCDCM_CSR_W-1:0] converter_status_reg,
	output logic [`DCDCM_WSR_W-1:0] wake_status_reg,
	output logic command_error_flag,
	output logic interrupt_out_n,
	output logic reset_out_n
);
	initial begin
		if (LEVELS != 4 || FAULT_W != `DCDCM_FAULT_W) begin
			$error("dcdcm_top: four voltage levels and fixed fault width");
		end
	end

	// ************************************************
	// Internal state
	// ************************************************
	dcdcm_mode_e mode_reg;
	dcdcm_mode_e mode_next;
	logic autoPwm_reg;
	logic lagDone;
	logic lagStart;
	logic stepUpAllow;
	logic stepUpActive;
	logic autoEvent;
	logic stopCmd;
	logic voltChangeBlocked;
	logic stopPwmWanted;

	assign stopCmd = modeCmdStb && (dcdcm_cmd_e'(modeCmd) == DCDCM_CMD_STOP);
	assign voltChangeBlocked = cfgWrStb && step_up_enable && (cfgStepUpSel != step_up_voltage_select); // RULE_04

	// ************************************************
	// Chip mode sequencing
	// ************************************************
	// Next mode from commands, wake and reset threshold
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			DCDCM_NORMAL, DCDCM_STOP: begin
				if (failSafeReq) begin
					mode_next = DCDCM_FAILSAFE;
				end else if (modeCmdStb) begin
					case (dcdcm_cmd_e'(modeCmd))
						DCDCM_CMD_NORMAL: mode_next = DCDCM_NORMAL; // RULE_16
						DCDCM_CMD_STOP: mode_next = DCDCM_STOP;
						DCDCM_CMD_SLEEP: mode_next = DCDCM_SLEEP;
						default: mode_next = mode_reg;
					endcase
				end
			end
			DCDCM_SLEEP, DCDCM_FAILSAFE: begin
				if (wakeEvent) begin
					mode_next = DCDCM_RESTART; // RULE_19
				end
			end
			DCDCM_RESTART: begin
				if (failSafeReq) begin
					mode_next = DCDCM_FAILSAFE;
				end else if (buckAboveRstTh) begin
					mode_next = DCDCM_NORMAL; // RULE_19
				end
			end
			default: mode_next = DCDCM_RESTART;
		endcase
	end

	// Mode register; pin faults are deliberately not an input here
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode_reg <= DCDCM_RESTART;
		end else begin
			mode_reg <= mode_next; // RULE_05
		end
	end

	// Mode visible to the rest of the chip
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			chipMode <= 3'h4;
		end else begin
			chipMode <= 3'(mode_next);
		end
	end

	// Reset output released once the step-down output passes its threshold
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reset_out_n <= 1'h0;
		end else if (mode_next == DCDCM_RESTART || mode_next == DCDCM_SLEEP || mode_next == DCDCM_FAILSAFE) begin
			reset_out_n <= 1'h0;
		end else begin
			reset_out_n <= 1'h1; // RULE_20
		end
	end

	// ************************************************
	// Configuration
	// ************************************************
	// Step-up enable accepted in Normal only; voltage change guarded
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			step_up_enable <= `DCDCM_RST_STEP_UP_EN;
			step_up_voltage_select <= `DCDCM_RST_STEP_UP_SEL;
		end else if (cfgWrStb && !voltChangeBlocked) begin
			if (mode_reg == DCDCM_NORMAL || !cfgStepUpEn) begin
				step_up_enable <= cfgStepUpEn; // RULE_01
			end
			step_up_voltage_select <= cfgStepUpSel; // RULE_01 RULE_21
		end
	end

	// Modulation options, auto switching off from reset
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			auto_pulse_width_switch <= `DCDCM_RST_AUTO_SW; // RULE_12
			wake_pin_modulation_select <= `DCDCM_RST_WAKE_SEL;
			mode_change_delay_select <= `DCDCM_RST_LAG_SEL;
		end else if (cfgWrStb && !voltChangeBlocked) begin
			auto_pulse_width_switch <= cfgAutoSwitch; // RULE_12
			wake_pin_modulation_select <= cfgWakeSel;
			mode_change_delay_select <= cfgLagSel; // RULE_14
		end
	end

	// Sticky error for a discarded write; a new error beats the clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			command_error_flag <= 1'h0;
		end else if (voltChangeBlocked) begin
			command_error_flag <= 1'h1; // RULE_04
		end else if (cmdErrorClr) begin
			command_error_flag <= 1'h0;
		end
	end

	// ************************************************
	// Step-up converter
	// ************************************************
	// Runs in Normal, Stop and Restart while enabled; untouched by Stop to Normal
	assign stepUpAllow = step_up_enable && (mode_reg == DCDCM_NORMAL || mode_reg == DCDCM_STOP
		|| mode_reg == DCDCM_RESTART); // RULE_17 RULE_18 RULE_20

	dcdcm_step_up_ctrl #(
		.LEVELS(LEVELS)
	) u_step_up (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.allow(stepUpAllow),
		.levelSel(step_up_voltage_select),
		.railBelowOnTh(railBelowOnTh), // RULE_22
		.railAboveOffTh(railAboveOffTh),
		.active(stepUpActive) // RULE_02
	);

	// Switching output, held off outside the active modes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stepUpSwitching <= 1'h0;
		end else begin
			stepUpSwitching <= stepUpActive && stepUpAllow; // RULE_18
		end
	end

	// ************************************************
	// Lag interval and automatic switching
	// ************************************************
	// Lag restarts on every Stop command in Normal or Stop: Stop entry or a repeated Stop
	assign lagStart = stopCmd && (mode_reg == DCDCM_NORMAL || mode_reg == DCDCM_STOP); // RULE_13

	dcdcm_lag_timer #(
		.CNT_W(LAG_CNT_W),
		.LONG_CYC(LAG_LONG_CYC),
		.SHORT_CYC(LAG_SHORT_CYC)
	) u_lag (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(lagStart),
		.abort(mode_reg != DCDCM_STOP && !lagStart),
		.longSel(mode_change_delay_select), // RULE_14
		.done(lagDone)
	);

	// Armed only after the lag, with auto switching set
	assign autoEvent = (mode_reg == DCDCM_STOP) && !lagStart && auto_pulse_width_switch && lagDone
		&& !autoPwm_reg && loadAbovePfmTh; // RULE_10 RULE_13

	// Latched PWM request, dropped by a new Stop command or leaving Stop
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			autoPwm_reg <= 1'h0;
		end else if (lagStart || mode_reg != DCDCM_STOP || !auto_pulse_width_switch) begin
			autoPwm_reg <= 1'h0; // RULE_11 RULE_12
		end else if (autoEvent) begin
			autoPwm_reg <= 1'h1; // RULE_10
		end
	end

	// Modulation wanted during Stop
	always_comb begin
		if (auto_pulse_width_switch) begin
			stopPwmWanted = autoPwm_reg || autoEvent; // RULE_08
		end else if (wake_pin_modulation_select) begin
			stopPwmWanted = wake_input_pin; // RULE_15
		end else begin
			stopPwmWanted = 1'h0; // RULE_09
		end
	end

	// ************************************************
	// Step-down converter
	// ************************************************
	// Enable, modulation and current allowance by mode
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			buckEnable <= 1'h0;
			buckPwm <= 1'h0;
			buckFullCurrent <= 1'h0;
		end else begin
			case (mode_next)
				DCDCM_NORMAL: begin
					buckEnable <= 1'h1;
					buckPwm <= 1'h1; // RULE_06 RULE_16
					buckFullCurrent <= 1'h1; // RULE_16
				end
				DCDCM_RESTART: begin
					buckEnable <= 1'h1; // RULE_20
					buckPwm <= 1'h1;
					buckFullCurrent <= 1'h1;
				end
				DCDCM_STOP: begin
					buckEnable <= 1'h1;
					buckPwm <= !lagStart && stopPwmWanted; // RULE_07
					buckFullCurrent <= !lagStart && stopPwmWanted;
				end
				default: begin
					buckEnable <= 1'h0; // RULE_18
					buckPwm <= 1'h0;
					buckFullCurrent <= 1'h0;
				end
			endcase
		end
	end

	// ************************************************
	// Status and interrupt
	// ************************************************
	// Converter status: active flag and pin faults, sticky; set beats clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			converter_status_reg <= '0;
		end else begin
			converter_status_reg[`DCDCM_CSR_ACTIVE_BIT] <= stepUpActive
				|| (converter_status_reg[`DCDCM_CSR_ACTIVE_BIT] && !convStatusClr); // RULE_03
			converter_status_reg[`DCDCM_CSR_FAULT_LSB +: `DCDCM_FAULT_W] <= pinFault
				| (convStatusClr ? '0 : converter_status_reg[`DCDCM_CSR_FAULT_LSB +: `DCDCM_FAULT_W]); // RULE_05
		end
	end

	// Wake status: modulation change and wake-up flags; set beats clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wake_status_reg <= '0;
		end else begin
			wake_status_reg[`DCDCM_WSR_MODCHG_BIT] <= autoEvent
				|| (wake_status_reg[`DCDCM_WSR_MODCHG_BIT] && !wakeStatusClr); // RULE_10
			wake_status_reg[`DCDCM_WSR_WAKE_BIT] <= (wakeEvent
				&& (mode_reg == DCDCM_SLEEP || mode_reg == DCDCM_FAILSAFE))
				|| (wake_status_reg[`DCDCM_WSR_WAKE_BIT] && !wakeStatusClr);
		end
	end

	// One-cycle low interrupt pulse on an automatic switch
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			interrupt_out_n <= 1'h1;
		end else begin
			interrupt_out_n <= !autoEvent; // RULE_10
		end
	end
endmodule : dcdcm_top
`default_nettype wire

// ===== rtl/dcdcm_consts.svh
/*
 * Constants of the converter mode control: timing, field positions, reset values.
 * Assumes inclusion by bare name from the files of this block.
 */
`ifndef DCDCM_CONSTS_SVH
`define DCDCM_CONSTS_SVH

// ************************************************
// Timing
// ************************************************
`define DCDCM_CLK_FREQ_MHZ 100
`define DCDCM_LAG_LONG_US 1000
`define DCDCM_LAG_SHORT_US 100
`define DCDCM_LAG_LONG_CYC (`DCDCM_LAG_LONG_US * `DCDCM_CLK_FREQ_MHZ)
`define DCDCM_LAG_SHORT_CYC (`DCDCM_LAG_SHORT_US * `DCDCM_CLK_FREQ_MHZ)

// ************************************************
// converter_status_reg fields
// ************************************************
`define DCDCM_CSR_ACTIVE_BIT 0
`define DCDCM_CSR_FAULT_LSB 1
`define DCDCM_FAULT_W 4
`define DCDCM_CSR_W 5

// ************************************************
// wake_status_reg fields
// ************************************************
`define DCDCM_WSR_MODCHG_BIT 0
`define DCDCM_WSR_WAKE_BIT 1
`define DCDCM_WSR_W 2

// ************************************************
// Reset values
// ************************************************
`define DCDCM_RST_STEP_UP_EN 1'h0
`define DCDCM_RST_STEP_UP_SEL 2'h0
`define DCDCM_RST_AUTO_SW 1'h0
`define DCDCM_RST_WAKE_SEL 1'h0
`define DCDCM_RST_LAG_SEL 1'h0

`endif

// ===== rtl/dcdcm_pkg.sv
/*
 * Types of the converter mode control.
 * Assumes nothing of its surroundings.
 */
package dcdcm_pkg;
	// Chip operating modes
	typedef enum logic [2:0] {
		DCDCM_NORMAL,
		DCDCM_STOP,
		DCDCM_SLEEP,
		DCDCM_FAILSAFE,
		DCDCM_RESTART
	} dcdcm_mode_e;

	// Mode commands from the controller
	typedef enum logic [1:0] {
		DCDCM_CMD_NORMAL,
		DCDCM_CMD_STOP,
		DCDCM_CMD_SLEEP,
		DCDCM_CMD_NONE
	} dcdcm_cmd_e;
endpackage : dcdcm_pkg

// ===== rtl/dcdcm_lag_timer.sv
/*
 * Lag interval timer: counts one of two lengths after a start pulse.
 * Assumes a synchronous active-low reset and one clock.
 */
`timescale 1ns/100ps
`default_nettype none
module dcdcm_lag_timer #(
	parameter int CNT_W = 17,
	parameter int LONG_CYC = 100000,
	parameter int SHORT_CYC = 10000
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic longSel,
	output logic done
);
	initial begin
		if (LONG_CYC < 1 || SHORT_CYC < 1 || LONG_CYC >= (2 ** CNT_W) || SHORT_CYC >= (2 ** CNT_W)) begin
			$error("dcdcm_lag_timer: counts do not fit");
		end
	end

	logic [CNT_W-1:0] count_reg;
	logic running_reg;

	// Load on start, count down to the end of the interval
	always_ff @(posedge core_clk) begin
		if (!rst_n || abort) begin
			count_reg <= '0;
			running_reg <= 1'h0;
			done <= 1'h0;
		end else if (start) begin
			count_reg <= longSel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
			running_reg <= 1'h1;
			done <= 1'h0;
		end else if (running_reg) begin
			if (count_reg == '0) begin
				running_reg <= 1'h0;
				done <= 1'h1;
			end else begin
				count_reg <= count_reg - 1'h1;
			end
		end
	end
endmodule : dcdcm_lag_timer
`default_nettype wire

// ===== rtl/dcdcm_step_up_ctrl.sv
/*
 * Step-up switching decision with hysteresis from per-level comparators.
 * Assumes comparator inputs synchronous and already filtered.
 */
`timescale 1ns/100ps
`default_nettype none
module dcdcm_step_up_ctrl #(
	parameter int LEVELS = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic allow,
	input wire logic [$clog2(LEVELS)-1:0] levelSel,
	input wire logic [LEVELS-1:0] railBelowOnTh,
	input wire logic [LEVELS-1:0] railAboveOffTh,
	output logic active
);
	initial begin
		if (LEVELS < 2) begin
			$error("dcdcm_step_up_ctrl: at least two levels");
		end
	end

	// Turn on below threshold, off above threshold plus hysteresis
	always_ff @(posedge core_clk) begin
		if (!rst_n || !allow) begin
			active <= 1'h0;
		end else if (railBelowOnTh[levelSel]) begin
			active <= 1'h1;
		end else if (railAboveOffTh[levelSel]) begin
			active <= 1'h0;
		end
	end
endmodule : dcdcm_step_up_ctrl
`default_nettype wire

// ===== verif/dcdcm_mcu_model.sv
/*
 * Controller model: configuration writes and mode commands as one-cycle strobes.
 * Assumes core_clk from the bench; the design samples strobes on the rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module dcdcm_mcu_model
	import dcdcm_pkg::*;
(
	input wire logic core_clk,
	output logic cfgWrStb,
	output logic cfgStepUpEn,
	output logic [1:0] cfgStepUpSel,
	output logic cfgAutoSwitch,
	output logic cfgWakeSel,
	output logic cfgLagSel,
	output logic modeCmdStb,
	output logic [1:0] modeCmd
);
	// Idle state of the command lines
	initial begin
		{cfgWrStb, modeCmdStb} = 2'h0;
		{cfgStepUpEn, cfgStepUpSel, cfgAutoSwitch, cfgWakeSel, cfgLagSel} = 6'h00;
		modeCmd = DCDCM_CMD_NONE;
	end
	// One write; data lines flip after the strobe so stale data is never reused
	task write_cfg(input logic en, input logic [1:0] sel, input logic au, input logic wk, input logic lg);
		@(posedge core_clk);
		cfgWrStb <= 1'h1;
		{cfgStepUpEn, cfgStepUpSel, cfgAutoSwitch, cfgWakeSel, cfgLagSel} <= {en, sel, au, wk, lg};
		@(posedge core_clk);
		cfgWrStb <= 1'h0;
		{cfgStepUpEn, cfgStepUpSel, cfgAutoSwitch, cfgWakeSel, cfgLagSel} <= ~{en, sel, au, wk, lg};
		#1;
	endtask : write_cfg
	// One mode command; a repeated Stop brings the step-down back to PFM
	task send_cmd(input dcdcm_cmd_e c);
		@(posedge core_clk);
		modeCmdStb <= 1'h1;
		modeCmd <= c;
		@(posedge core_clk);
		modeCmdStb <= 1'h0;
		modeCmd <= DCDCM_CMD_NONE;
		#1;
	endtask : send_cmd
endmodule : dcdcm_mcu_model
`default_nettype wire

// ===== verif/dcdcm_checker.sv
/*
 * Port-level assertions on the converter mode control.
 * Assumes binding to dcdcm_top with default four levels and four fault bits.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dcdcm_consts.svh"
module dcdcm_checker
	import dcdcm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cfgWrStb,
	input wire logic [1:0] cfgStepUpSel,
	input wire logic modeCmdStb,
	input wire logic [1:0] modeCmd,
	input wire logic failSafeReq,
	input wire logic wakeEvent,
	input wire logic wake_input_pin,
	input wire logic buckAboveRstTh,
	input wire logic [2:0] chipMode,
	input wire logic buckEnable,
	input wire logic buckPwm,
	input wire logic buckFullCurrent,
	input wire logic stepUpSwitching,
	input wire logic step_up_enable,
	input wire logic [1:0] step_up_voltage_select,
	input wire logic auto_pulse_width_switch,
	input wire logic wake_pin_modulation_select,
	input wire logic [`DCDCM_CSR_W-1:0] converter_status_reg,
	input wire logic [`DCDCM_WSR_W-1:0] wake_status_reg,
	input wire logic command_error_flag,
	input wire logic interrupt_out_n,
	input wire logic reset_out_n
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic stopCmd = modeCmdStb && modeCmd == DCDCM_CMD_STOP && !failSafeReq;
	wire logic inStop = chipMode == DCDCM_STOP;
	wire logic asleep = chipMode == DCDCM_SLEEP || chipMode == DCDCM_FAILSAFE;
	// A Stop command that starts a PWM-to-PFM change
	sequence pfm_start;
		stopCmd && (inStop || chipMode == DCDCM_NORMAL);
	endsequence
	a_stop_goes_pfm: assert property (pfm_start |=> inStop && !buckPwm) else $error("no PFM after Stop");
	a_lag_holds_pfm: assert property (pfm_start ##0 auto_pulse_width_switch |=> !buckPwm [*4])
		else $error("PWM inside lag");
	a_normal_pwm: assert property (chipMode == DCDCM_NORMAL |-> buckPwm && buckEnable) else $error("Normal not PWM");
	a_sleep_buck_off: assert property (asleep |-> !buckEnable) else $error("step-down on while off");
	a_sleep_boost_off: assert property (asleep [*3] |-> !stepUpSwitching) else $error("step-up on while off");
	a_bad_sel_write: assert property (cfgWrStb && step_up_enable && cfgStepUpSel != step_up_voltage_select
		|=> command_error_flag && $stable(step_up_voltage_select)) else $error("level change accepted");
	a_auto_irq: assert property ($fell(interrupt_out_n) |-> buckPwm && wake_status_reg[`DCDCM_WSR_MODCHG_BIT]
		##1 interrupt_out_n) else $error("bad switch interrupt");
	a_stop_stays_pfm: assert property ((inStop && !auto_pulse_width_switch && !wake_pin_modulation_select) [*2]
		|-> !buckPwm) else $error("PWM with no selection");
	a_pin_follows: assert property (inStop && wake_pin_modulation_select && !auto_pulse_width_switch && !cfgWrStb
		&& !modeCmdStb && !failSafeReq |=> buckPwm == $past(wake_input_pin)) else $error("pin not followed");
	a_wake_restart: assert property (asleep && wakeEvent |=> chipMode == DCDCM_RESTART && !reset_out_n)
		else $error("wake missed");
	a_reset_release: assert property (chipMode == DCDCM_RESTART && buckAboveRstTh && !failSafeReq
		|=> chipMode == DCDCM_NORMAL && reset_out_n) else $error("reset not released");
	a_to_normal: assert property (inStop && modeCmdStb && modeCmd == DCDCM_CMD_NORMAL && !failSafeReq
		|=> chipMode == DCDCM_NORMAL && buckPwm && buckFullCurrent) else $error("bad Stop exit");
	a_active_flag: assert property (stepUpSwitching |-> converter_status_reg[`DCDCM_CSR_ACTIVE_BIT])
		else $error("active flag missing");
endmodule : dcdcm_checker
bind dcdcm_top dcdcm_checker dcdcm_checker_i (.core_clk, .rst_n, .cfgWrStb, .cfgStepUpSel, .modeCmdStb, .modeCmd,
	.failSafeReq, .wakeEvent, .wake_input_pin, .buckAboveRstTh, .chipMode, .buckEnable, .buckPwm, .buckFullCurrent,
	.stepUpSwitching, .step_up_enable, .step_up_voltage_select, .auto_pulse_width_switch, .wake_pin_modulation_select,
	.converter_status_reg, .wake_status_reg, .command_error_flag, .interrupt_out_n, .reset_out_n);
`default_nettype wire

// ===== verif/tb.sv
/*
 * Self-checking bench of the converter mode control.
 * Assumes the controller model drives all configuration and command strobes.
 */
`timescale 1ns/100ps
`default_nettype none
module tb
	import dcdcm_pkg::*;
;
	// ****************
	// Signals
	// ****************
	localparam int SHORT = 5;
	localparam int LONG = 20;
	logic core_clk, rst_n, failSafeReq, wakeEvent, wake_input_pin, loadAbovePfmTh, buckAboveRstTh;
	logic [3:0] railBelowOnTh, railAboveOffTh, pinFault;
	logic cfgWrStb, cfgStepUpEn, cfgAutoSwitch, cfgWakeSel, cfgLagSel, modeCmdStb;
	logic [1:0] cfgStepUpSel, modeCmd, step_up_voltage_select;
	logic [2:0] chipMode;
	logic buckEnable, buckPwm, buckFullCurrent, stepUpSwitching, step_up_enable, auto_pulse_width_switch;
	logic wake_pin_modulation_select, mode_change_delay_select, command_error_flag, interrupt_out_n, reset_out_n;
	logic [4:0] converter_status_reg;
	logic [1:0] wake_status_reg;
	int err_total = 0;
	int checked = 0;
	int irqSeen = 0;
	dcdcm_mcu_model mcu_i (.core_clk, .cfgWrStb, .cfgStepUpEn, .cfgStepUpSel, .cfgAutoSwitch, .cfgWakeSel,
		.cfgLagSel, .modeCmdStb, .modeCmd);
	dcdcm_top #(.LAG_LONG_CYC(LONG), .LAG_SHORT_CYC(SHORT)) dcdcm_top_i (.core_clk, .rst_n, .cfgWrStb, .cfgStepUpEn,
		.cfgStepUpSel, .cfgAutoSwitch, .cfgWakeSel, .cfgLagSel, .modeCmdStb, .modeCmd, .failSafeReq, .wakeEvent,
		.wake_input_pin, .loadAbovePfmTh, .buckAboveRstTh, .railBelowOnTh, .railAboveOffTh, .pinFault,
		.convStatusClr(1'h0), .wakeStatusClr(1'h0), .cmdErrorClr(1'h0), .chipMode, .buckEnable, .buckPwm,
		.buckFullCurrent, .stepUpSwitching, .step_up_enable, .step_up_voltage_select, .auto_pulse_width_switch,
		.wake_pin_modulation_select, .mode_change_delay_select, .converter_status_reg, .wake_status_reg,
		.command_error_flag, .interrupt_out_n, .reset_out_n);
	// Clock
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	// Count interrupt pulses
	always @(posedge core_clk) if (interrupt_out_n === 1'h0) irqSeen++;
	// ****************
	// Tasks
	// ****************
	task step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Stop command with load already high: PFM through the lag, then PWM
	task lag_run(input int lag);
		int irq0;
		irq0 = irqSeen;
		mcu_i.send_cmd(DCDCM_CMD_STOP);
		step(lag - 1);
		chk(buckPwm, 1'h0);
		step(4);
		chk({buckPwm, buckFullCurrent, wake_status_reg[0]}, 3'h7);
		chk(8'(irqSeen), 8'(irq0 + 1));
	endtask : lag_run
	// Wake from an off mode through Restart into Normal
	task wake_up;
		@(posedge core_clk) begin
			wakeEvent <= 1'h1;
			buckAboveRstTh <= 1'h0;
		end
		@(posedge core_clk) wakeEvent <= 1'h0;
		step(3);
		chk({chipMode, reset_out_n, stepUpSwitching, buckEnable, wake_status_reg[1]}, 7'h47);
		@(posedge core_clk) buckAboveRstTh <= 1'h1;
		step(2);
		chk({chipMode, reset_out_n}, 4'h1);
	endtask : wake_up
	task wrap_up;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	// Watchdog
	initial begin
		#50us;
		err_total++;
		wrap_up();
	end
	// ****************
	// Tests
	// ****************
	initial begin
		{rst_n, failSafeReq, wakeEvent, wake_input_pin, loadAbovePfmTh, buckAboveRstTh} = 6'h00;
		{railBelowOnTh, railAboveOffTh, pinFault} = 12'h000;
		step(8);
		chk({chipMode, reset_out_n, auto_pulse_width_switch, step_up_enable}, 6'h20);
		@(posedge core_clk) rst_n <= 1'h1;
		step(2);
		chk({chipMode, buckEnable}, 4'h9);
		@(posedge core_clk) buckAboveRstTh <= 1'h1;
		step(2);
		chk({chipMode, reset_out_n, buckPwm}, 5'h03);
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			mcu_i.write_cfg(1'h0, 2'(c), 1'h0, 1'h0, 1'h0);
			chk(step_up_voltage_select, 8'(c));
		end
		mcu_i.write_cfg(1'h1, 2'h2, 1'h0, 1'h0, 1'h0);
		chk(step_up_enable, 1'h1);
		@(posedge core_clk) railBelowOnTh <= 4'h2;
		step(3);
		chk(stepUpSwitching, 1'h0);
		@(posedge core_clk) railBelowOnTh <= 4'h4;
		step(3);
		chk({stepUpSwitching, converter_status_reg[0]}, 2'h3);
		mcu_i.write_cfg(1'h1, 2'h3, 1'h0, 1'h0, 1'h0);
		chk({command_error_flag, step_up_voltage_select}, 3'h6);
		@(posedge core_clk) pinFault <= 4'hF;
		step(3);
		chk(converter_status_reg, 5'h1F);
		chk({chipMode, step_up_enable, step_up_voltage_select}, 6'h06);
		mcu_i.send_cmd(DCDCM_CMD_STOP);
		chk({chipMode, buckPwm, buckFullCurrent}, 5'h04);
		mcu_i.send_cmd(DCDCM_CMD_NORMAL);
		chk({chipMode, buckPwm, buckFullCurrent, stepUpSwitching}, 6'h07);
		@(posedge core_clk) {railBelowOnTh, railAboveOffTh} <= 8'h04;
		step(3);
		chk(stepUpSwitching, 1'h0);
		$display("test step-up done");
		mcu_i.write_cfg(1'h1, 2'h2, 1'h1, 1'h0, 1'h0);
		@(posedge core_clk) loadAbovePfmTh <= 1'h1;
		lag_run(SHORT);
		mcu_i.write_cfg(1'h1, 2'h2, 1'h1, 1'h1, 1'h1);
		chk({auto_pulse_width_switch, wake_pin_modulation_select, mode_change_delay_select}, 3'h7);
		@(posedge core_clk) wake_input_pin <= 1'h1;
		lag_run(LONG);
		mcu_i.send_cmd(DCDCM_CMD_NORMAL);
		$display("test auto switch done");
		mcu_i.write_cfg(1'h1, 2'h2, 1'h0, 1'h1, 1'h0);
		@(posedge core_clk) {railBelowOnTh, railAboveOffTh} <= 8'h40;
		mcu_i.send_cmd(DCDCM_CMD_STOP);
		for (int v = 0; v < 3; v++) begin
			@(posedge core_clk) wake_input_pin <= ~v[0];
			step(2);
			chk(buckPwm, !v[0]);
		end
		mcu_i.write_cfg(1'h1, 2'h2, 1'h0, 1'h0, 1'h0);
		step(2);
		chk(buckPwm, 1'h0);
		$display("test wake pin done");
		mcu_i.send_cmd(DCDCM_CMD_SLEEP);
		step(3);
		chk({chipMode, buckEnable, stepUpSwitching}, 5'h08);
		wake_up();
		@(posedge core_clk) failSafeReq <= 1'h1;
		@(posedge core_clk) failSafeReq <= 1'h0;
		step(3);
		chk({chipMode, buckEnable, stepUpSwitching}, 5'h0C);
		wake_up();
		$display("test off modes done");
		wrap_up();
	end
endmodule : tb
`default_nettype wire
